// file: copper_port_ctrl_status_regs_bench.sv
module copper_port_ctrl_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpsr_pkg::*;
  logic          clk, rst, reg_wr, reg_rd, page_rcvd, peer_on, peer_full;
  logic          tx_pause_res, rx_pause_res, mdix_auto, energy_sleep;
  logic          pol_reversed, jabber_det, an_complete, link_up, irq;
  logic          port_power_down, soft_reset, an_restart, an_enable;
  logic          pol_correct_en, jabber_en, duplex_res, seen;
  logic [1:0]    speed_res, peer_speed, xover_mode, energy_mode;
  logic [3:0]    pair_pol;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rv;
  int            n_errors, n_checks;

  cpsr_regs dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .an_complete(an_complete), .page_rcvd(page_rcvd), .link_up(link_up),
    .speed_res(speed_res), .duplex_res(duplex_res),
    .tx_pause_res(tx_pause_res), .rx_pause_res(rx_pause_res),
    .mdix_auto(mdix_auto), .energy_sleep(energy_sleep),
    .pol_reversed(pol_reversed), .pair_pol(pair_pol),
    .jabber_det(jabber_det), .port_power_down(port_power_down),
    .soft_reset(soft_reset), .an_restart(an_restart),
    .an_enable(an_enable), .pol_correct_en(pol_correct_en),
    .jabber_en(jabber_en), .xover_mode(xover_mode),
    .energy_mode(energy_mode), .irq(irq)
  );
  cpsr_port_model #(.AN_CYC(8)) u_peer (
    .clk(clk), .rst(rst), .port_power_down(port_power_down),
    .soft_reset(soft_reset), .an_restart(an_restart), .peer_on(peer_on),
    .peer_speed(peer_speed), .peer_full(peer_full),
    .an_complete(an_complete), .link_up(link_up), .speed_res(speed_res),
    .duplex_res(duplex_res)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic chk(input logic [DW-1:0] s, input logic [DW-1:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  // Early wait lets the reset or restart pulse drop the old result
  task automatic renego(input logic [DW-1:0] d);
    wr(ADDR_BASIC_CTRL, d);
    repeat (4) @(posedge clk);
    repeat (60) if (an_complete !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : renego

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic t_reset;
    rd(ADDR_STAT_ONE);
    chk(rv, 16'h8040);
    rd(ADDR_CTRL_ONE);
    chk(rv & 16'h0007, 16'h0000);
    chk(16'(energy_mode), 16'(ED_RST));
    rd(ADDR_BASIC_CTRL);
    chk(rv, 16'h1000);
    $display("reset test done");
  endtask : t_reset

  task automatic t_speeds;
    for (int i = 0; i < 6; i++) begin
      peer_speed   <= 2'(i >> 1);
      peer_full    <= i[0];
      tx_pause_res <= i[0];
      rx_pause_res <= !i[0];
      renego(16'h1200);
      rd(ADDR_STAT_ONE);
      chk(rv & 16'hef08, {2'(i >> 1), i[0], 3'h3, i[0], !i[0],
          4'h0, 1'b1, 3'h0});
    end
    peer_on <= 1'b0;
    wr(ADDR_BASIC_CTRL, 16'h0000);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0c08, 16'h0800);
    peer_on <= 1'b1;
    $display("speed test done");
  endtask : t_speeds

  task automatic t_power;
    wr(ADDR_CTRL_ONE, 16'h0064);
    repeat (2) @(posedge clk);
    chk(16'(port_power_down), 16'h0001);
    wr(ADDR_BASIC_CTRL, 16'h1800);
    wr(ADDR_CTRL_ONE, 16'h0060);
    repeat (3) @(posedge clk);
    chk(16'(port_power_down), 16'h0001);
    wr(ADDR_BASIC_CTRL, 16'h1000);
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1 if ((soft_reset & an_restart) === 1'b1) seen = 1'b1;
    end
    chk(16'(seen), 16'h0001);
    chk(16'(port_power_down), 16'h0000);
    $display("power test done");
  endtask : t_power

  task automatic t_polj;
    peer_speed   <= SPEED_10;
    peer_full    <= 1'b0;
    pol_reversed <= 1'b1;
    jabber_det   <= 1'b1;
    energy_sleep <= 1'b1;
    pair_pol     <= 4'h5;
    renego(16'h1200);
    wr(ADDR_CTRL_ONE, 16'h0063);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0013, 16'h0010);
    chk(16'({pol_correct_en, jabber_en}), 16'h0000);
    wr(ADDR_CTRL_ONE, 16'h0060);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0013, 16'h0013);
    chk(16'({pol_correct_en, jabber_en}), 16'h0003);
    peer_full <= 1'b1;
    renego(16'h1200);
    chk(16'(jabber_en), 16'h0000);
    peer_speed <= SPEED_1000;
    renego(16'h1200);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0002, 16'h0000);
    rd(ADDR_PAIR_POL);
    chk(rv, 16'h0005);
    $display("polarity test done");
  endtask : t_polj

  task automatic t_page;
    wr(ADDR_INT_MASK, 16'h1000);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      page_rcvd <= 1'b1;
      @(posedge clk);
      page_rcvd <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(16'(irq), 16'(1 - m));
      wr(ADDR_INT_STAT, 16'h1000);
      @(posedge clk);
      #1 chk(16'(irq), 16'h0000);
      wr(ADDR_INT_MASK, 16'h0000);
    end
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h1000, 16'h1000);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h1000, 16'h0000);
    $display("page test done");
  endtask : t_page

  task automatic t_xover;
    wr(ADDR_CTRL_ONE, 16'h0000);
    renego(16'h1200);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0040, 16'h0040);
    mdix_auto <= 1'b0;
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0040, 16'h0000);
    mdix_auto <= 1'b1;
    renego(16'h9000);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0040, 16'h0000);
    wr(ADDR_CTRL_ONE, 16'h0020);
    renego(16'h9000);
    rd(ADDR_STAT_ONE);
    chk(rv & 16'h0040, 16'h0040);
    chk(16'(xover_mode), 16'(XC_MDIX));
    $display("crossover test done");
  endtask : t_xover

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    rst          = 1'b1;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 5'h00;
    reg_wdata    = 16'h0000;
    page_rcvd    = 1'b0;
    peer_on      = 1'b1;
    peer_speed   = SPEED_1000;
    peer_full    = 1'b1;
    tx_pause_res = 1'b0;
    rx_pause_res = 1'b0;
    mdix_auto    = 1'b1;
    energy_sleep = 1'b0;
    pol_reversed = 1'b0;
    pair_pol     = 4'h0;
    jabber_det   = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_speeds();
    t_power();
    t_polj();
    t_page();
    t_xover();
    tally_and_finish();
  end
endmodule : copper_port_ctrl_status_regs_bench

bind cpsr_regs cpsr_regs_sva u_sva (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .an_complete(an_complete), .an_enable(an_enable),
  .page_rcvd(page_rcvd), .link_up(link_up), .speed_res(speed_res),
  .duplex_res(duplex_res), .port_power_down(port_power_down),
  .soft_reset(soft_reset), .an_restart(an_restart),
  .pol_correct_en(pol_correct_en), .jabber_en(jabber_en)
);

// file: cpsr_lh_bit.sv
module cpsr_lh_bit (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Event and clears
  input  wire logic event_in,
  input  wire logic rd_clr,
  input  wire logic sw_clr,
  // State
  output logic      flag
);
  import cpsr_pkg::*;

  // Event present during the clearing read keeps the bit set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (event_in) begin
      flag <= 1'b1;
    end else if (rd_clr || sw_clr) begin
      flag <= 1'b0;
    end
  end

endmodule : cpsr_lh_bit

// file: cpsr_pkg.sv
package cpsr_pkg;

  localparam int AW = 5;
  localparam int DW = 16;

  // Register offsets
  localparam logic [AW-1:0] ADDR_BASIC_CTRL = 5'h00;
  localparam logic [AW-1:0] ADDR_CTRL_ONE   = 5'h10;
  localparam logic [AW-1:0] ADDR_STAT_ONE   = 5'h11;
  localparam logic [AW-1:0] ADDR_PAIR_POL   = 5'h15;
  localparam logic [AW-1:0] ADDR_INT_STAT   = 5'h1a;
  localparam logic [AW-1:0] ADDR_INT_MASK   = 5'h1b;

  // Basic control fields
  localparam int BC_RESET   = 15;
  localparam int BC_AN_EN   = 12;
  localparam int BC_PDOWN   = 11;
  localparam int BC_RESTART = 9;

  // Control one fields
  localparam int C1_ED_LO   = 8;
  localparam int C1_XC_LO   = 5;
  localparam int C1_RSVD4   = 4;
  localparam int C1_PDOWN   = 2;
  localparam int C1_POL_DIS = 1;
  localparam int C1_JAB_DIS = 0;

  // Status one fields
  localparam int S1_SPEED_LO = 14;
  localparam int S1_DUPLEX   = 13;
  localparam int S1_PAGE     = 12;
  localparam int S1_RESOLVED = 11;
  localparam int S1_LINK_RT  = 10;
  localparam int S1_TX_PAUSE = 9;
  localparam int S1_RX_PAUSE = 8;
  localparam int S1_XOVER    = 6;
  localparam int S1_SLEEP    = 4;
  localparam int S1_GLINK    = 3;
  localparam int S1_POL_RT   = 1;
  localparam int S1_JABBER   = 0;

  // Interrupt status and mask layout
  localparam int IS_SPEED  = 14;
  localparam int IS_DUPLEX = 13;
  localparam int IS_PAGE   = 12;
  localparam int IS_RESOLV = 11;
  localparam int IS_LINK   = 10;
  localparam int IS_XOVER  = 6;
  localparam int IS_ENERGY = 4;
  localparam int IS_POL    = 1;
  localparam int IS_JABBER = 0;
  localparam logic [DW-1:0] INT_IMPL = 16'h7c53;

  // Encodings and reset values
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_RST  = SPEED_1000;
  localparam logic [1:0] XC_MDI     = 2'h0;
  localparam logic [1:0] XC_MDIX    = 2'h1;
  localparam logic [1:0] XC_AUTO    = 2'h3;
  localparam logic       XOVER_RST  = 1'b1;
  localparam logic [1:0] ED_RST     = 2'h0;
  localparam logic       AN_EN_RST  = 1'b1;

endpackage : cpsr_pkg

// file: cpsr_port_model.sv
module cpsr_port_model #(
  parameter int AN_CYC = 8
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Controls from the block
  input  wire logic       port_power_down,
  input  wire logic       soft_reset,
  input  wire logic       an_restart,
  // Far end settings
  input  wire logic       peer_on,
  input  wire logic [1:0] peer_speed,
  input  wire logic       peer_full,
  // Resolution results
  output logic            an_complete,
  output logic            link_up,
  output logic [1:0]      speed_res,
  output logic            duplex_res
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (port_power_down || soft_reset || an_restart || !peer_on) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != AN_CYC[4:0]) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  assign an_complete = (cnt_q == AN_CYC[4:0]);
  assign link_up     = an_complete;
  // Unresolved results inverted so stale values never pass
  assign speed_res   = an_complete ? peer_speed : ~peer_speed;
  assign duplex_res  = an_complete ? peer_full : ~peer_full;
endmodule : cpsr_port_model

// file: cpsr_regs.sv
// Chosen here: the strobed register port.
module cpsr_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Register port
  input  wire logic [cpsr_pkg::AW-1:0]  reg_addr,
  input  wire logic [cpsr_pkg::DW-1:0]  reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [cpsr_pkg::DW-1:0]  reg_rdata,
  // Resolution results from the port
  input  wire logic                     an_complete,
  input  wire logic                     page_rcvd,
  input  wire logic                     link_up,
  input  wire logic [1:0]               speed_res,
  input  wire logic                     duplex_res,
  input  wire logic                     tx_pause_res,
  input  wire logic                     rx_pause_res,
  input  wire logic                     mdix_auto,
  input  wire logic                     energy_sleep,
  input  wire logic                     pol_reversed,
  input  wire logic [3:0]               pair_pol,
  input  wire logic                     jabber_det,
  // Controls to the port
  output logic                          port_power_down,
  output logic                          soft_reset,
  output logic                          an_restart,
  output logic                          an_enable,
  output logic                          pol_correct_en,
  output logic                          jabber_en,
  output logic      [1:0]               xover_mode,
  output logic      [1:0]               energy_mode,
  // Interrupt
  output logic                          irq
);
  import cpsr_pkg::*;

  // Basic control
  logic            an_en_q;
  logic            basic_pd_q;
  logic            reset_req_q;
  logic            restart_req_q;

  // Control one
  logic [1:0]      ed_mode_q;
  logic [1:0]      xc_wr_q;
  logic            rsvd4_q;
  logic            ctrl_pd_q;
  logic            pol_dis_q;
  logic            jab_dis_q;

  // Active state
  logic [1:0]      xc_act_q;
  logic            pd_q;

  // Status one
  logic [1:0]      speed_q;
  logic            duplex_q;
  logic            xover_q;
  logic            resolved_d;
  logic            page_flag;
  logic            pol_rt_d;
  logic            jabber_rt_d;

  // Event history for interrupts
  logic            link_p_q;
  logic            res_p_q;
  logic            sleep_p_q;
  logic            pol_p_q;
  logic            jab_p_q;
  logic [DW-1:0]   int_stat_q;
  logic [DW-1:0]   int_mask_q;
  logic [DW-1:0]   int_evt;

  // Bus decode
  logic            wr_basic;
  logic            wr_ctrl;
  logic            wr_istat;
  logic            wr_imask;
  logic            rd_stat;
  logic            pd_d;
  logic            pd_exit;
  logic            sw_rst;
  logic [DW-1:0]   stat_word;
  logic [DW-1:0]   rdata_d;

  function automatic logic hit(input logic         strobe,
                               input logic [AW-1:0] a,
                               input logic [AW-1:0] target);
    hit = strobe && (a == target);
  endfunction : hit

  assign wr_basic = hit(reg_wr, reg_addr, ADDR_BASIC_CTRL);
  assign wr_ctrl  = hit(reg_wr, reg_addr, ADDR_CTRL_ONE);
  assign wr_istat = hit(reg_wr, reg_addr, ADDR_INT_STAT);
  assign wr_imask = hit(reg_wr, reg_addr, ADDR_INT_MASK);
  assign rd_stat  = hit(reg_rd, reg_addr, ADDR_STAT_ONE);

  // Basic control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      an_en_q    <= AN_EN_RST;
      basic_pd_q <= 1'b0;
    end else if (wr_basic) begin
      an_en_q    <= reg_wdata[BC_AN_EN];
      basic_pd_q <= reg_wdata[BC_PDOWN];
    end
  end

  // Reset and restart requests are self-clearing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_req_q   <= 1'b0;
      restart_req_q <= 1'b0;
    end else begin
      reset_req_q   <= wr_basic && reg_wdata[BC_RESET];
      restart_req_q <= wr_basic && reg_wdata[BC_RESTART];
    end
  end

  // Control one register; all written bits retain over soft reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ed_mode_q <= ED_RST;
      xc_wr_q   <= XC_AUTO;
      rsvd4_q   <= 1'b0;
      ctrl_pd_q <= 1'b0;
      pol_dis_q <= 1'b0;
      jab_dis_q <= 1'b0;
    end else if (wr_ctrl) begin
      ed_mode_q <= reg_wdata[C1_ED_LO +: 2];
      xc_wr_q   <= reg_wdata[C1_XC_LO +: 2];
      rsvd4_q   <= reg_wdata[C1_RSVD4];
      ctrl_pd_q <= reg_wdata[C1_PDOWN];
      pol_dis_q <= reg_wdata[C1_POL_DIS];
      jab_dis_q <= reg_wdata[C1_JAB_DIS];
    end
  end

  // Power down follows either bit; exit only once both are clear
  assign pd_d    = basic_pd_q | ctrl_pd_q;
  assign pd_exit = pd_q && !pd_d;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= pd_d;
    end
  end

  // Leaving power down forces a reset and restart without software
  assign sw_rst = reset_req_q | pd_exit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_reset <= 1'b0;
      an_restart <= 1'b0;
    end else begin
      soft_reset <= sw_rst;
      an_restart <= restart_req_q | pd_exit;
    end
  end

  // Crossover mode is disruptive, so it only lands on soft reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xc_act_q <= XC_AUTO;
    end else if (sw_rst) begin
      xc_act_q <= xc_wr_q;
    end
  end

  assign port_power_down = pd_q;
  assign an_enable       = an_en_q;
  assign xover_mode      = xc_act_q;
  assign energy_mode     = ed_mode_q;

  // Polarity correction and jabber gating
  assign pol_correct_en = !pol_dis_q;
  assign jabber_en      = !jab_dis_q && speed_q == SPEED_10
                          && !duplex_q && resolved_d;

  // Resolution held high while negotiation is off
  assign resolved_d = !an_en_q || an_complete;

  // Speed, duplex and crossover captured while resolved
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_q  <= SPEED_RST;
      duplex_q <= 1'b0;
    end else if (resolved_d) begin
      speed_q  <= speed_res;
      duplex_q <= duplex_res;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xover_q <= XOVER_RST;
    end else if (resolved_d) begin
      if (xc_act_q == XC_MDI || xc_act_q == XC_MDIX) begin
        xover_q <= (xc_act_q == XC_MDIX);
      end else begin
        xover_q <= mdix_auto;
      end
    end
  end

  // Page received latches until read; soft reset clears it
  cpsr_lh_bit u_page (
    .clk      (clk),
    .rst      (rst),
    .event_in (page_rcvd),
    .rd_clr   (rd_stat),
    .sw_clr   (sw_rst),
    .flag     (page_flag)
  );

  // Forced normal polarity in 10BASE-T when reversal disabled
  always_comb begin
    pol_rt_d = pol_reversed;
    if (pol_dis_q && speed_q == SPEED_10) begin
      pol_rt_d = 1'b0;
    end
    if (speed_q == SPEED_1000) begin
      pol_rt_d = 1'b0;
    end
  end

  assign jabber_rt_d = jabber_det && jabber_en;

  // Status one word
  always_comb begin
    stat_word = '0;
    stat_word[S1_SPEED_LO +: 2] = speed_q;
    stat_word[S1_DUPLEX]        = duplex_q;
    stat_word[S1_PAGE]          = page_flag;
    stat_word[S1_RESOLVED]      = resolved_d;
    stat_word[S1_LINK_RT]       = link_up;
    stat_word[S1_TX_PAUSE]      = tx_pause_res;
    stat_word[S1_RX_PAUSE]      = rx_pause_res;
    stat_word[S1_XOVER]         = xover_q;
    stat_word[S1_SLEEP]         = energy_sleep;
    stat_word[S1_GLINK]         = link_up;
    stat_word[S1_POL_RT]        = pol_rt_d;
    stat_word[S1_JABBER]        = jabber_rt_d;
  end

  // History of levels for change events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_p_q  <= 1'b0;
      res_p_q   <= 1'b0;
      sleep_p_q <= 1'b0;
      pol_p_q   <= 1'b0;
      jab_p_q   <= 1'b0;
    end else begin
      link_p_q  <= link_up;
      res_p_q   <= resolved_d;
      sleep_p_q <= energy_sleep;
      pol_p_q   <= pol_rt_d;
      jab_p_q   <= jabber_rt_d;
    end
  end

  // Change events; speed, duplex, crossover seen on register update
  logic [1:0] speed_p_q;
  logic       duplex_p_q;
  logic       xover_p_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_p_q  <= SPEED_RST;
      duplex_p_q <= 1'b0;
      xover_p_q  <= XOVER_RST;
    end else begin
      speed_p_q  <= speed_q;
      duplex_p_q <= duplex_q;
      xover_p_q  <= xover_q;
    end
  end

  always_comb begin
    int_evt            = '0;
    int_evt[IS_SPEED]  = speed_q != speed_p_q;
    int_evt[IS_DUPLEX] = duplex_q != duplex_p_q;
    int_evt[IS_PAGE]   = page_rcvd;
    int_evt[IS_RESOLV] = resolved_d && !res_p_q;
    int_evt[IS_LINK]   = link_up != link_p_q;
    int_evt[IS_XOVER]  = xover_q != xover_p_q;
    int_evt[IS_ENERGY] = energy_sleep != sleep_p_q;
    int_evt[IS_POL]    = pol_rt_d != pol_p_q;
    int_evt[IS_JABBER] = jabber_rt_d && !jab_p_q;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= ((int_stat_q & ~(wr_istat ? reg_wdata : '0))
                     | int_evt) & INT_IMPL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_mask_q <= '0;
    end else if (wr_imask) begin
      int_mask_q <= reg_wdata & INT_IMPL;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      ADDR_BASIC_CTRL: begin
        rdata_d[BC_AN_EN] = an_en_q;
        rdata_d[BC_PDOWN] = basic_pd_q;
      end
      ADDR_CTRL_ONE: begin
        rdata_d[C1_ED_LO +: 2] = ed_mode_q;
        rdata_d[C1_XC_LO +: 2] = xc_wr_q;
        rdata_d[C1_RSVD4]      = rsvd4_q;
        rdata_d[C1_PDOWN]      = ctrl_pd_q;
        rdata_d[C1_POL_DIS]    = pol_dis_q;
        rdata_d[C1_JAB_DIS]    = jab_dis_q;
      end
      ADDR_STAT_ONE: begin
        rdata_d = stat_word;
      end
      ADDR_PAIR_POL: begin
        if (speed_q == SPEED_1000) begin
          rdata_d[3:0] = pair_pol;
        end
      end
      ADDR_INT_STAT: begin
        rdata_d = int_stat_q;
      end
      ADDR_INT_MASK: begin
        rdata_d = int_mask_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : cpsr_regs

// file: cpsr_regs_sva.sv
module cpsr_regs_sva (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Register port
  input wire logic [cpsr_pkg::AW-1:0] reg_addr,
  input wire logic [cpsr_pkg::DW-1:0] reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [cpsr_pkg::DW-1:0] reg_rdata,
  // Port side
  input wire logic                    an_complete,
  input wire logic                    an_enable,
  input wire logic                    page_rcvd,
  input wire logic                    link_up,
  input wire logic [1:0]              speed_res,
  input wire logic                    duplex_res,
  input wire logic                    port_power_down,
  input wire logic                    soft_reset,
  input wire logic                    an_restart,
  input wire logic                    pol_correct_en,
  input wire logic                    jabber_en
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpsr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  AST_PD_SET: assert property (
    s_wr(ADDR_CTRL_ONE) ##0 reg_wdata[C1_PDOWN] |-> ##2 port_power_down)
    else $error("power down not entered");
  AST_PD_EXIT: assert property (
    $fell(port_power_down) |-> ##[0:2] (soft_reset && an_restart))
    else $error("no reset on power up");
  AST_SRST: assert property (
    soft_reset |=> !soft_reset)
    else $error("soft reset pulse too long");
  AST_POL: assert property (
    s_wr(ADDR_CTRL_ONE) |=>
      pol_correct_en == !$past(reg_wdata[C1_POL_DIS]))
    else $error("polarity control wrong");
  AST_JAB: assert property (
    s_wr(ADDR_CTRL_ONE) ##0 reg_wdata[C1_JAB_DIS] |=> !jabber_en)
    else $error("jabber not disabled");
  AST_SPD: assert property (
    s_rd(ADDR_STAT_ONE) ##0 (an_complete && $past(an_complete) &&
      $stable(speed_res) && $stable(duplex_res)) |=>
      reg_rdata[S1_SPEED_LO +: 2] == $past(speed_res) &&
      reg_rdata[S1_DUPLEX] == $past(duplex_res))
    else $error("speed or duplex status wrong");
  AST_RESOLV: assert property (
    s_rd(ADDR_STAT_ONE) ##0 !an_enable |=> reg_rdata[S1_RESOLVED])
    else $error("resolved flag low with negotiation off");
  AST_LINK: assert property (
    s_rd(ADDR_STAT_ONE) ##0 $stable(link_up) |=>
      reg_rdata[S1_LINK_RT] == $past(link_up) &&
      reg_rdata[S1_GLINK] == $past(link_up))
    else $error("link status wrong");
  AST_PAGE_CLR: assert property (
    s_rd(ADDR_STAT_ONE) ##0 (!page_rcvd)[*3] ##0 s_rd(ADDR_STAT_ONE)
      |=> !reg_rdata[S1_PAGE])
    else $error("page flag not cleared by read");
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
endmodule : cpsr_regs_sva
